// ==== tb/eprgm_ctrl_test.sv ====
// Self-checking testbench of the memory programmer controller
`timescale 1ns/1ps
module eprgm_ctrl_test;
    import eprgm_pkg::*;
    logic        ref_clk;
    logic        reset_n;
    logic        reqValid;
    eprgm_req_t  req;
    logic        busy;
    logic        rspValid;
    eprgm_rsp_t  rsp;
    eprgm_pins_t pins;
    logic [7:0]  memData;
    logic        slow;
    int          n_mismatch;
    int          comparisons;
    int          nPulse;

    eprgm_ctrl #(.PULSE_CYCLES(20), .MAX_PULSES(25)) dut_u (
        .ref_clk(ref_clk), .reset_n(reset_n), .reqValid(reqValid), .req(req),
        .busy(busy), .rspValid(rspValid), .rsp(rsp), .pins(pins), .memData(memData));

    eprgm_mem_model mem_u (.pins(pins), .slow(slow), .memData(memData));

    always #50 ref_clk = ~ref_clk;

    always @(negedge pins.chipSelectProgramStrobe_n) if (pins.vppOn === 1'b1) nPulse++;

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic wrap_up;
        if (n_mismatch == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Trigger line and low address lines during identifier readout
    always @(negedge ref_clk) if (pins.idModeTriggerHv === 1'b1)
        check({1'b0, pins.addr[15:1]}, 16'h0000, "id address");

    task automatic run_op(input eprgm_op_t op, input logic [15:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge ref_clk); #10;
        nPulse = 0;
        reqValid = 1'b1;
        req = '{op: op, addr: a, data: d};
        @(posedge ref_clk); #10;
        reqValid = 1'b0;
        check({15'h0000, busy}, 16'h0001, "busy after request");
        while ((rspValid !== 1'b1 || busy !== 1'b0) && n < 5000) begin
            @(posedge ref_clk); #10;
            n++;
        end
        check({15'h0000, n < 5000}, 16'h0001, "answer timeout");
        check({13'h0000, pins.chipSelectProgramStrobe_n, pins.vppOn, pins.idModeTriggerHv},
              16'h0004, "idle pins");
    endtask

    task automatic t_read_erased;
        run_op(EPRGM_OP_READ, 16'h1234, 8'h00);
        check({8'h00, rsp.data}, 16'h00FF, "erased byte");
        check({15'h0000, rsp.ok}, 16'h0001, "read ok");
    endtask

    task automatic t_program_fast;
        run_op(EPRGM_OP_PROG, 16'hFFFF, 8'hA5);
        check({15'h0000, rsp.ok}, 16'h0001, "program ok");
        check(nPulse[15:0], 16'h0001, "single pulse");
        run_op(EPRGM_OP_READ, 16'hFFFF, 8'h00);
        check({8'h00, rsp.data}, 16'h00A5, "read back");
        run_op(EPRGM_OP_READ, 16'h0000, 8'h00);
        check({8'h00, rsp.data}, 16'h00FF, "neighbour untouched");
    endtask

    task automatic t_program_slow;
        slow = 1'b1;
        run_op(EPRGM_OP_PROG, 16'h0100, 8'h00);
        check({15'h0000, rsp.ok}, 16'h0001, "slow program ok");
        check(nPulse[15:0], 16'h0008, "pulses until verified");
        slow = 1'b0;
    endtask

    task automatic t_program_fail;
        run_op(EPRGM_OP_PROG, 16'h0100, 8'h0F);
        check({15'h0000, rsp.ok}, 16'h0000, "failed program");
        check(nPulse[15:0], 16'h0019, "pulse limit");
    endtask

    task automatic t_ident;
        run_op(EPRGM_OP_ID, 16'h0000, 8'h00);
        check({7'h00, rsp.parityOk, rsp.data}, 16'h013B, "maker code");
        run_op(EPRGM_OP_ID, 16'h0001, 8'h00);
        check({7'h00, rsp.parityOk, rsp.data}, 16'h015D, "part code");
    endtask

    initial begin
        ref_clk = 1'b0;
        reset_n = 1'b0;
        reqValid = 1'b0;
        req = '0;
        slow = 1'b0;
        nPulse = 0;
        n_mismatch = 0;
        comparisons = 0;
        repeat (3) @(posedge ref_clk);
        #10;
        reset_n = 1'b1;
        t_read_erased();
        t_program_fast();
        t_program_slow();
        t_program_fail();
        t_ident();
        wrap_up();
    end

    // Watchdog well beyond the longest expected run
    initial begin
        #(100 * 30000);
        n_mismatch++;
        wrap_up();
    end
endmodule

// ==== tb/eprgm_mem_model.sv ====
// Behavioural model of the programmable memory facing the controller
`timescale 1ns/1ps
module eprgm_mem_model #(
    parameter logic [7:0] MAKER_CODE = 8'h3B,  // Arbitrary value, odd parity
    parameter logic [7:0] PART_CODE  = 8'h5D   // Arbitrary value, odd parity
) (
    input  wire eprgm_pkg::eprgm_pins_t pins,     // Pins from the controller
    input  wire logic                   slow,     // One bit cleared per pulse
    output logic [7:0]                  memData   // Data pins toward controller
);
    import eprgm_pkg::*;
    logic [7:0] mem [logic [15:0]];
    logic [7:0] word;
    logic [7:0] cur;
    logic [7:0] want;
    logic       valid;

    function automatic logic [7:0] lookup(input logic [15:0] a);
        return mem.exists(a) ? mem[a] : 8'hFF;
    endfunction

    initial begin
        valid = 1'b0;
        word  = 8'h00;
    end

    // Program on a low pulse with supply high, read byte or identifier otherwise
    always @(negedge pins.chipSelectProgramStrobe_n) begin
        valid = 1'b0;
        if (pins.vppOn === 1'b1) begin
            cur  = lookup(pins.addr);
            want = cur & ~pins.dataOut;
            mem[pins.addr] = slow ? (cur & ~(want & (~want + 8'h01))) : (cur & pins.dataOut);
        end else begin
            #450;
            if (pins.idModeTriggerHv === 1'b1)
                word = (pins.addr[15:1] != 15'h0000) ? 8'h00 :
                       (pins.addr[0] ? PART_CODE : MAKER_CODE);
            else
                word = lookup(pins.addr);
            valid = !pins.chipSelectProgramStrobe_n;
        end
    end

    always @(posedge pins.chipSelectProgramStrobe_n) valid = 1'b0;

    // Released pins show the inverse, never a stale match
    assign memData = (valid && !pins.outGate_n && !pins.vppOn) ? word : ~word;
endmodule

// ==== verilog/eprgm_ctrl.sv ====
// Programmer controller driving the memory pins: read, program, verify, id
`timescale 1ns/1ps
// Notes on behaviour
// - Chip-select strobe is the primary per-device selection signal.
// - Output gate follows the read strobe, common to all devices.
// - Only the chip-select/program strobe differs between parallel devices.
// - Programmed locations are read back to confirm every bit.
// - Verify holds output gate and strobe low; memory drives stored byte.
// - Verify data is sampled only after the verify data delay.
// - Identifier mode needs the trigger line at elevated voltage.
// - Other address lines stay low during identifier readout.
// - Short program pulses, repeated only until the data verifies.
module eprgm_ctrl #(
    parameter int PULSE_CYCLES = eprgm_pkg::PULSE_CYC,  // Program pulse length
    parameter int MAX_PULSES   = eprgm_pkg::MAX_TRIES   // Pulse limit per byte
) (
    input  wire logic                 ref_clk,   // 10 MHz clock
    input  wire logic                 reset_n,   // Async reset, active low
    input  wire logic                 reqValid,  // Request strobe, one cycle
    input  wire eprgm_pkg::eprgm_req_t req,      // Request fields
    output logic                      busy,      // Operation in progress
    output logic                      rspValid,  // Answer pulse
    output eprgm_pkg::eprgm_rsp_t     rsp,       // Answer fields
    output eprgm_pkg::eprgm_pins_t    pins,      // Pins toward memory
    input  wire logic [7:0]           memData    // Memory data pins, input side
);
    import eprgm_pkg::*;

    typedef enum logic [2:0] {
        EPRGM_IDLE   = 3'b000,
        EPRGM_SETUP  = 3'b001,
        EPRGM_PULSE  = 3'b010,
        EPRGM_RECOV  = 3'b011,
        EPRGM_VERIFY = 3'b100,
        EPRGM_SAMPLE = 3'b101,
        EPRGM_FLOAT  = 3'b110
    } eprgm_state_t;

    function automatic logic oddParity(input logic [7:0] b);
        oddParity = ^b;
    endfunction

    eprgm_state_t state;
    eprgm_req_t   cur;
    logic [31:0]  count;
    logic [7:0]   tries;
    logic [7:0]   dataSync;
    logic [7:0]   rdByte;

    eprgm_sync #(.WIDTH(8)) u_sync (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .din     (memData),
        .dout    (dataSync)
    );

    // Settle time covers three synchroniser stages plus its output flop after the verify delay
    localparam int SAMPLE_CYC = VDD_CYC + 4;

    wire countDone = (count == 32'h0000_0000);
    wire isProg    = (cur.op == EPRGM_OP_PROG);
    wire isId      = (cur.op == EPRGM_OP_ID);
    wire match     = (rdByte == cur.data);
    wire lastTry   = (tries >= MAX_PULSES[7:0]);
    // Id readout: only select line carried, others low
    wire [15:0] idAddr = {15'h0000, req.addr[0]};

    // ------------------------------------------------------------------------
    // Sequencer, busy registered together with the state
    // ------------------------------------------------------------------------

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state    <= EPRGM_IDLE;
            cur      <= '0;
            count    <= 32'h0000_0000;
            tries    <= 8'h00;
            rdByte   <= 8'h00;
            rspValid <= 1'b0;
            rsp      <= '0;
            busy     <= 1'b0;
            pins.addr <= 16'h0000;
            pins.chipSelectProgramStrobe_n <= 1'b1;
            pins.outGate_n       <= 1'b1;
            pins.vppOn           <= 1'b0;
            pins.idModeTriggerHv <= 1'b0;
            pins.dataOut         <= 8'h00;
            pins.dataOe          <= 1'b0;
        end else begin
            rspValid <= 1'b0;
            if (!countDone) begin
                count <= count - 32'h0000_0001;
            end
            case (state)
                EPRGM_IDLE: begin
                    if (reqValid) begin
                        cur   <= req;
                        busy  <= 1'b1;
                        tries <= 8'h00;
                        pins.addr <= (req.op == EPRGM_OP_ID) ? idAddr : req.addr;
                        pins.idModeTriggerHv <= (req.op == EPRGM_OP_ID);
                        if (req.op == EPRGM_OP_PROG) begin
                            // Strobe stays high while supply rises: inhibit
                            pins.vppOn   <= 1'b1;
                            pins.dataOut <= req.data;
                            pins.dataOe  <= 1'b1;
                            state <= EPRGM_SETUP;
                        end else begin
                            state <= EPRGM_VERIFY;
                        end
                        count <= SETUP_CYC;
                    end
                end
                EPRGM_SETUP: begin
                    if (countDone) begin
                        pins.chipSelectProgramStrobe_n <= 1'b0;
                        count <= PULSE_CYCLES;
                        tries <= tries + 8'h01;
                        state <= EPRGM_PULSE;
                    end
                end
                EPRGM_PULSE: begin
                    if (countDone) begin
                        pins.chipSelectProgramStrobe_n <= 1'b1;
                        count <= SETUP_CYC;
                        state <= EPRGM_RECOV;
                    end
                end
                EPRGM_RECOV: begin
                    if (countDone) begin
                        pins.dataOe <= 1'b0;
                        pins.vppOn  <= 1'b0;
                        count <= SETUP_CYC;
                        state <= EPRGM_VERIFY;
                    end
                end
                EPRGM_VERIFY: begin
                    if (countDone) begin
                        pins.outGate_n                 <= 1'b0;
                        pins.chipSelectProgramStrobe_n <= 1'b0;
                        count <= SAMPLE_CYC;
                        state <= EPRGM_SAMPLE;
                    end
                end
                EPRGM_SAMPLE: begin
                    if (countDone) begin
                        rdByte <= dataSync;
                        pins.outGate_n                 <= 1'b1;
                        pins.chipSelectProgramStrobe_n <= 1'b1;
                        count <= FLOAT_CYC;
                        state <= EPRGM_FLOAT;
                    end
                end
                EPRGM_FLOAT: begin
                    if (countDone) begin
                        if (isProg && !match && !lastTry) begin
                            pins.vppOn   <= 1'b1;
                            pins.dataOut <= cur.data;
                            pins.dataOe  <= 1'b1;
                            count <= SETUP_CYC;
                            state <= EPRGM_SETUP;
                        end else begin
                            rspValid      <= 1'b1;
                            busy          <= 1'b0;
                            rsp.data      <= rdByte;
                            rsp.ok        <= isProg ? match : 1'b1;
                            rsp.parityOk  <= isId ? oddParity(rdByte) : 1'b1;
                            pins.idModeTriggerHv <= 1'b0;
                            pins.addr <= 16'h0000;
                            state <= EPRGM_IDLE;
                        end
                    end
                end
                default: begin
                    state <= EPRGM_IDLE;
                    busy  <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    sequence s_pulse_start;
        $fell(pins.chipSelectProgramStrobe_n) && pins.vppOn;
    endsequence

    property p_inhibit_high;
        @(posedge ref_clk) disable iff (!reset_n)
        (state == EPRGM_SETUP) |-> pins.chipSelectProgramStrobe_n;
    endproperty
    a_inhibit_high: assert property (p_inhibit_high) else $error("strobe low in setup");

    property p_pulse_len;
        @(posedge ref_clk) disable iff (!reset_n)
        s_pulse_start |-> ##1 (state == EPRGM_PULSE) && !pins.chipSelectProgramStrobe_n;
    endproperty
    a_pulse_len: assert property (p_pulse_len) else $error("program pulse broke");

    property p_verify_pins;
        @(posedge ref_clk) disable iff (!reset_n)
        (state == EPRGM_SAMPLE) |-> !pins.outGate_n && !pins.vppOn && !pins.dataOe;
    endproperty
    a_verify_pins: assert property (p_verify_pins) else $error("verify pins wrong");

    property p_id_addr;
        @(posedge ref_clk) disable iff (!reset_n)
        pins.idModeTriggerHv |-> (pins.addr[15:1] == 15'h0000);
    endproperty
    a_id_addr: assert property (p_id_addr) else $error("id address high");

    property p_tries;
        @(posedge ref_clk) disable iff (!reset_n)
        tries <= MAX_PULSES[7:0];
    endproperty
    a_tries: assert property (p_tries) else $error("too many pulses");

    property p_idle_deselect;
        @(posedge ref_clk) disable iff (!reset_n)
        (state == EPRGM_IDLE) |-> pins.chipSelectProgramStrobe_n && pins.outGate_n;
    endproperty
    a_idle_deselect: assert property (p_idle_deselect) else $error("idle not standby");

    property p_no_drive_on_read;
        @(posedge ref_clk) disable iff (!reset_n)
        !pins.outGate_n |-> !pins.dataOe;
    endproperty
    a_no_drive_on_read: assert property (p_no_drive_on_read) else $error("bus clash");

    property p_id_trigger;
        @(posedge ref_clk) disable iff (!reset_n)
        (state == EPRGM_SAMPLE && isId) |-> pins.idModeTriggerHv;
    endproperty
    a_id_trigger: assert property (p_id_trigger) else $error("trigger low in id");
endmodule

// ==== verilog/eprgm_pkg.sv ====
// Package: constants and types for the memory programmer controller
package eprgm_pkg;
    localparam int ADDR_W   = 16;
    localparam int DATA_W   = 8;
    localparam int CLK_NS   = 100;
    // Program pulse width, 1 ms nominal, in microseconds
    localparam int PULSE_US = 1000;
    localparam int PULSE_CYC = (PULSE_US * 1000) / CLK_NS;
    // Setup and hold times, 2 us least
    localparam int SETUP_NS  = 2000;
    localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
    // Verify data delay, 450 ns longest at the memory, wait it out
    localparam int VDD_NS    = 450;
    localparam int VDD_CYC   = (VDD_NS + CLK_NS - 1) / CLK_NS;
    // Float delay after strobe release, 150 ns
    localparam int FLOAT_NS  = 150;
    localparam int FLOAT_CYC = (FLOAT_NS + CLK_NS - 1) / CLK_NS;
    localparam int MAX_TRIES = 25;
    localparam logic [7:0] TRY_W = 8'h19;

    typedef enum logic [1:0] {
        EPRGM_OP_READ = 2'b00,
        EPRGM_OP_PROG = 2'b01,
        EPRGM_OP_ID   = 2'b10
    } eprgm_op_t;

    // Request from user side
    typedef struct packed {
        eprgm_op_t         op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } eprgm_req_t;

    // Answer to user side
    typedef struct packed {
        logic              ok;
        logic              parityOk;
        logic [DATA_W-1:0] data;
    } eprgm_rsp_t;

    // Pins toward the memory
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic              chipSelectProgramStrobe_n;
        logic              outGate_n;
        logic              vppOn;
        logic              idModeTriggerHv;
        logic [DATA_W-1:0] dataOut;
        logic              dataOe;
    } eprgm_pins_t;
endpackage

// ==== verilog/eprgm_sync.sv ====
// Three-stage input synchroniser with agreement of last two stages
`timescale 1ns/1ps
module eprgm_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             ref_clk,  // Clock
    input  wire logic             reset_n,  // Async reset
    input  wire logic [WIDTH-1:0] din,      // Asynchronous input
    output logic      [WIDTH-1:0] dout      // Settled value
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    wire  [WIDTH-1:0] agree = ~(stage2 ^ stage3);

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
            dout   <= '0;
        end else begin
            stage1 <= din;
            stage2 <= stage1;
            stage3 <= stage2;
            dout   <= (stage3 & agree) | (dout & ~agree);
        end
    end
endmodule
